// file: common/an_pkg.sv
// auto-negotiation control package: timing, register map, states
// assumes a single 50 MHz system clock
package an_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  // link interval times in microseconds
  localparam int SGMII_TIMER_US = 1600;
  localparam int GBE_TIMER_US = 10000;
  localparam int SHORT_TIMER_US = 2;
  localparam int SGMII_TIMER_CYC = SGMII_TIMER_US * CYC_PER_US;
  localparam int GBE_TIMER_CYC = GBE_TIMER_US * CYC_PER_US;
  localparam int SHORT_TIMER_CYC = SHORT_TIMER_US * CYC_PER_US;
  localparam int TMR_W = 20;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LOCAL = 8'h04;
  localparam logic [7:0] OFS_PARTNER = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // control field positions
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_RESTART = 1;
  localparam int CTRL_SIDE = 2;
  localparam int CTRL_SHORT = 3;
  localparam int CTRL_GBE = 4;
  localparam logic [4:0] CTRL_RESET = 5'h01;
  localparam logic [15:0] LOCAL_RESET = 16'h0001;
  // status field positions
  localparam int STAT_PAGE = 4;
  localparam int STAT_DONE = 5;
  // interrupt bits
  localparam int IRQ_PAGE = 0;
  localparam int IRQ_LINK_UP = 1;
  localparam int IRQ_LINK_DOWN = 2;
  localparam int IRQ_RESTART = 3;
  localparam int IRQ_N = 4;
  // ability word details
  localparam logic [15:0] MAC_SIDE_WORD = 16'h4001;
  localparam int ACK_BIT = 14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_RESTART = 3'h0,
    ST_ABILITY = 3'h1,
    ST_ACK_DET = 3'h3,
    ST_COMPLETE_ACK = 3'h2,
    ST_IDLE_DET = 3'h6,
    ST_LINK_OK = 3'h7,
    ST_DISABLED = 3'h5
  } an_state_t;
endpackage

// file: common/timer_if.sv
// carrier between negotiation control and its link interval timer
// assumes both ends share the system clock
`timescale 1ns/1ps
`default_nettype none
interface timer_if;
  logic start;
  logic short_mode;
  logic gbe_mode;
  logic expired;
  modport ctl (output start, output short_mode, output gbe_mode, input expired);
  modport tmr (input start, input short_mode, input gbe_mode, output expired);
endinterface
`default_nettype wire

// file: hw/an_control.sv
// auto-negotiation control for a gigabit / SGMII coding sublayer
// assumes link-side inputs come from receive logic on the same clock
//
// Notes on behaviour
// - partner ability output shows received word
// - negotiation runs only while enable is high
// - restart request sends machine back to start
// - side select 0 is MAC, 1 is PHY
// - normal timer 1.6 ms SGMII, 10 ms 1000BASE-X
// - short timer setting gives 2 us interval
// - PHY side restarts on local ability change
// - idles after acknowledge, link-OK after timer
`timescale 1ns/1ps
`default_nettype none
module an_control #(
  parameter int SGMII_CYC = an_pkg::SGMII_TIMER_CYC,
  parameter int GBE_CYC = an_pkg::GBE_TIMER_CYC,
  parameter int SHORT_CYC = an_pkg::SHORT_TIMER_CYC
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // axi4-lite write address
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // axi4-lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read address
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // axi4-lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // receive side of the link
  input wire logic RX_CFG_VALID,
  input wire logic [15:0] RX_CFG_WORD,
  input wire logic RX_IDLE,
  input wire logic SYNC_OK,
  // transmit side of the link
  output logic TX_CFG_SEND,
  output logic [15:0] TX_CFG_WORD,
  output logic TX_IDLE_SEND,
  // status
  output logic [15:0] PARTNER_ABILITY_WORD,
  output logic PAGE_RECEIVED_FLAG,
  output logic NEGOTIATION_DONE_FLAG,
  output logic IRQ
);
  import an_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // registers and state

  logic negotiation_enable;
  logic negotiation_restart_request;
  logic side_phy;
  logic short_timer;
  logic gbe_mode;
  logic [15:0] local_ability_word;
  logic [15:0] partner_ability_word;
  logic [15:0] last_local;
  logic [IRQ_N-1:0] irq_stat;
  logic [IRQ_N-1:0] irq_mask;
  logic [IRQ_N-1:0] irq_event;
  an_state_t state;
  an_state_t next_state;
  logic timer_start;
  logic restart_event;
  logic ability_change;

  // axi holding registers
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [31:0] wr_merge;
  logic [31:0] rd_word;
  logic rd_hit;

  timer_if tif ();

  link_timer #(
    .SGMII_CYC(SGMII_CYC),
    .GBE_CYC(GBE_CYC),
    .SHORT_CYC(SHORT_CYC)
  ) u_timer (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .tif(tif)
  );

  // timer length follows the mode bits
  assign tif.start = timer_start;
  assign tif.short_mode = short_timer;
  assign tif.gbe_mode = gbe_mode;

  ////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  assign S_AXI_AWREADY = !aw_held;
  assign S_AXI_WREADY = !w_held;
  assign wr_fire = aw_held && w_held && !S_AXI_BVALID;

  // address and data taken in either order
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (S_AXI_WVALID && !w_held) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // response after both halves are in
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= (aw_addr <= OFS_IRQ_MASK && aw_addr[1:0] == 2'h0) ?
                     RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // byte lanes merged over the current register value
  always_comb begin
    unique case (aw_addr)
      OFS_CTRL: wr_merge = {27'h0, gbe_mode, short_timer, side_phy, 1'b0,
                            negotiation_enable};
      OFS_LOCAL: wr_merge = {16'h0, local_ability_word};
      OFS_IRQ_MASK: wr_merge = {28'h0, irq_mask};
      default: wr_merge = 32'h0000_0000;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (w_strb[i]) begin
        wr_merge[8*i +: 8] = w_data[8*i +: 8];
      end
    end
  end

  // software-written control
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      {gbe_mode, short_timer, side_phy} <= CTRL_RESET[4:2];
      negotiation_enable <= CTRL_RESET[CTRL_ENABLE];
      negotiation_restart_request <= 1'b0;
      local_ability_word <= LOCAL_RESET;
      irq_mask <= '0;
    end else begin
      negotiation_restart_request <= 1'b0;
      if (wr_fire) begin
        unique case (aw_addr)
          OFS_CTRL: begin
            negotiation_enable <= wr_merge[CTRL_ENABLE];
            negotiation_restart_request <= wr_merge[CTRL_RESTART];
            side_phy <= wr_merge[CTRL_SIDE];
            short_timer <= wr_merge[CTRL_SHORT];
            gbe_mode <= wr_merge[CTRL_GBE];
          end
          OFS_LOCAL: local_ability_word <= wr_merge[15:0];
          OFS_IRQ_MASK: irq_mask <= wr_merge[IRQ_N-1:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  // read decode
  always_comb begin
    rd_hit = 1'b1;
    unique case (S_AXI_ARADDR)
      OFS_CTRL: rd_word = {27'h0, gbe_mode, short_timer, side_phy, 1'b0,
                           negotiation_enable};
      OFS_LOCAL: rd_word = {16'h0, local_ability_word};
      OFS_PARTNER: rd_word = {16'h0, partner_ability_word};
      OFS_STATUS: rd_word = {26'h0, NEGOTIATION_DONE_FLAG, PAGE_RECEIVED_FLAG,
                             1'b0, state};
      OFS_IRQ_STAT: rd_word = {28'h0, irq_stat};
      OFS_IRQ_MASK: rd_word = {28'h0, irq_mask};
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // read answer held until taken
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_word;
      S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // negotiation state machine

  // phy side watches its own advertised word
  assign ability_change = side_phy && (local_ability_word != last_local);
  assign restart_event = negotiation_restart_request || !SYNC_OK ||
                         ability_change;

  // next state
  always_comb begin
    next_state = state;
    timer_start = 1'b0;
    if (!negotiation_enable) begin
      next_state = ST_DISABLED;
    end else if (restart_event) begin
      next_state = ST_RESTART;
      timer_start = 1'b1;
    end else begin
      unique case (state)
        ST_DISABLED: begin
          next_state = ST_RESTART;
          timer_start = 1'b1;
        end
        ST_RESTART: begin
          if (tif.expired) begin
            next_state = ST_ABILITY;
          end
        end
        ST_ABILITY: begin
          if (RX_CFG_VALID && RX_CFG_WORD != 16'h0000) begin
            next_state = ST_ACK_DET;
          end
        end
        ST_ACK_DET: begin
          if (RX_CFG_VALID && RX_CFG_WORD[ACK_BIT]) begin
            next_state = ST_COMPLETE_ACK;
            timer_start = 1'b1;
          end
        end
        ST_COMPLETE_ACK: begin
          if (tif.expired) begin
            next_state = ST_IDLE_DET;
            timer_start = 1'b1;
          end
        end
        ST_IDLE_DET: begin
          if (RX_CFG_VALID && RX_CFG_WORD == 16'h0000) begin
            next_state = ST_RESTART;
            timer_start = 1'b1;
          end else if (tif.expired && RX_IDLE) begin
            next_state = ST_LINK_OK;
          end
        end
        ST_LINK_OK: begin
          if (RX_CFG_VALID) begin
            next_state = ST_RESTART;
            timer_start = 1'b1;
          end
        end
        default: begin
          next_state = ST_RESTART;
          timer_start = 1'b1;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= ST_DISABLED;
    end else begin
      state <= next_state;
    end
  end

  // snapshot of the advertised word for change detection
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      last_local <= LOCAL_RESET;
    end else begin
      last_local <= local_ability_word;
    end
  end

  // partner word captured on each page received in ability or acknowledge detect
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      partner_ability_word <= 16'h0000;
    end else if (RX_CFG_VALID &&
                 (state == ST_ABILITY || state == ST_ACK_DET)) begin
      partner_ability_word <= RX_CFG_WORD;
    end
  end

  assign PARTNER_ABILITY_WORD = partner_ability_word;

  ////////////////////////////////////////////////////////////////////
  // transmit selection and status flags

  // config word: zero in restart and disabled, fixed on mac side in SGMII mode, advertised word otherwise
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      TX_CFG_SEND <= 1'b0;
      TX_IDLE_SEND <= 1'b0;
      TX_CFG_WORD <= 16'h0000;
    end else begin
      TX_CFG_SEND <= (next_state == ST_RESTART) || (next_state == ST_ABILITY) ||
                     (next_state == ST_ACK_DET) || (next_state == ST_COMPLETE_ACK);
      TX_IDLE_SEND <= (next_state == ST_IDLE_DET) || (next_state == ST_LINK_OK) ||
                      (next_state == ST_DISABLED);
      if (next_state == ST_RESTART || next_state == ST_DISABLED) begin
        TX_CFG_WORD <= 16'h0000;
      end else if (!side_phy && !gbe_mode) begin
        TX_CFG_WORD <= MAC_SIDE_WORD;
      end else begin
        TX_CFG_WORD <= local_ability_word;
        TX_CFG_WORD[ACK_BIT] <= (next_state == ST_ACK_DET) ||
                                (next_state == ST_COMPLETE_ACK);
      end
    end
  end

  // flags follow the state directly
  assign PAGE_RECEIVED_FLAG = (state == ST_COMPLETE_ACK);
  assign NEGOTIATION_DONE_FLAG = (state == ST_LINK_OK);

  ////////////////////////////////////////////////////////////////////
  // interrupts

  // events on state entry and exit, restart on any restart cause while enabled
  always_comb begin
    irq_event = '0;
    irq_event[IRQ_PAGE] = (next_state == ST_COMPLETE_ACK) &&
                          (state != ST_COMPLETE_ACK);
    irq_event[IRQ_LINK_UP] = (next_state == ST_LINK_OK) && (state != ST_LINK_OK);
    irq_event[IRQ_LINK_DOWN] = (state == ST_LINK_OK) && (next_state != ST_LINK_OK);
    irq_event[IRQ_RESTART] = negotiation_enable && restart_event;
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_stat <= '0;
    end else if (wr_fire && aw_addr == OFS_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~(wr_merge[IRQ_N-1:0])) | irq_event;
    end else begin
      irq_stat <= irq_stat | irq_event;
    end
  end

  assign IRQ = |(irq_stat & irq_mask);
endmodule
`default_nettype wire

// file: hw/link_timer.sv
// link interval timer, restartable, with a selectable length
// assumes start is a one-cycle pulse on the system clock
`timescale 1ns/1ps
`default_nettype none
module link_timer #(
  parameter int SGMII_CYC = an_pkg::SGMII_TIMER_CYC,
  parameter int GBE_CYC = an_pkg::GBE_TIMER_CYC,
  parameter int SHORT_CYC = an_pkg::SHORT_TIMER_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control side
  timer_if.tmr tif
);
  import an_pkg::*;
  logic [TMR_W-1:0] count;
  logic [TMR_W-1:0] length;
  logic running;
  logic done;

  if (SGMII_CYC < 1 || GBE_CYC < 1 || SHORT_CYC < 1 || SHORT_CYC >= (1 << TMR_W) ||
      SGMII_CYC >= (1 << TMR_W) || GBE_CYC >= (1 << TMR_W)) begin : g_chk
    $error("link timer length out of range");
  end

  // selected interval length
  always_comb begin
    if (tif.short_mode) begin
      length = TMR_W'(SHORT_CYC);
    end else if (tif.gbe_mode) begin
      length = TMR_W'(GBE_CYC);
    end else begin
      length = TMR_W'(SGMII_CYC);
    end
  end

  // count down, expiry held until the next start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else if (tif.start) begin
      count <= length - TMR_W'(1);
      running <= 1'b1;
      done <= 1'b0;
    end else if (running) begin
      if (count == '0) begin
        running <= 1'b0;
        done <= 1'b1;
      end else begin
        count <= count - TMR_W'(1);
      end
    end
  end

  assign tif.expired = done;
endmodule
`default_nettype wire

// file: tb/an_control_checker.sv
// checker: port-level assertions on the negotiation block
// assumes it is bound into an_control, one system clock
`timescale 1ns/1ps
`default_nettype none
module an_control_checker #(
  parameter int GBE_CYC = 60,
  parameter int SHORT_CYC = 10
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // link side
  input wire logic RX_CFG_VALID,
  input wire logic [15:0] RX_CFG_WORD,
  input wire logic RX_IDLE,
  input wire logic SYNC_OK,
  input wire logic TX_CFG_SEND,
  input wire logic [15:0] TX_CFG_WORD,
  input wire logic TX_IDLE_SEND,
  // status
  input wire logic [15:0] PARTNER_ABILITY_WORD,
  input wire logic PAGE_RECEIVED_FLAG,
  input wire logic NEGOTIATION_DONE_FLAG
);
  import an_pkg::*;
  int zero_len;
  logic zero_tx;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////
  // length of the zero-word restart phase
  assign zero_tx = TX_CFG_WORD == 16'h0000 && !TX_IDLE_SEND && SYNC_OK;
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      zero_len <= 0;
    end else begin
      zero_len <= zero_tx ? zero_len + 1 : 0;
    end
  end
  // properties
  property p_tmr_max; zero_tx |-> zero_len <= GBE_CYC + 3; endproperty
  property p_tmr_min; zero_len != 0 && TX_CFG_WORD != 16'h0000 |-> zero_len >= SHORT_CYC;
  endproperty
  property p_page_ack; PAGE_RECEIVED_FLAG |-> TX_CFG_SEND && TX_CFG_WORD[ACK_BIT]; endproperty
  property p_page_in; $rose(PAGE_RECEIVED_FLAG) |-> $past(RX_CFG_VALID) && $past(RX_CFG_WORD[14]);
  endproperty
  property p_word_in; $rose(PAGE_RECEIVED_FLAG) |-> PARTNER_ABILITY_WORD == $past(RX_CFG_WORD);
  endproperty
  property p_word_hold; NEGOTIATION_DONE_FLAG |-> $stable(PARTNER_ABILITY_WORD); endproperty
  property p_done_idle; NEGOTIATION_DONE_FLAG |-> TX_IDLE_SEND && !TX_CFG_SEND; endproperty
  property p_done_in; $rose(NEGOTIATION_DONE_FLAG) |-> $past(RX_IDLE) && $past(TX_IDLE_SEND);
  endproperty
  property p_sync_loss; !SYNC_OK |=> !NEGOTIATION_DONE_FLAG && !PAGE_RECEIVED_FLAG; endproperty
  a_tmr_max: assert property (p_tmr_max) else $error("restart phase too long");
  a_tmr_min: assert property (p_tmr_min) else $error("restart phase too short");
  a_page_ack: assert property (p_page_ack) else $error("page flag without ack word");
  a_page_in: assert property (p_page_in) else $error("page flag without ack input");
  a_word_in: assert property (p_word_in) else $error("partner word not captured");
  a_word_hold: assert property (p_word_hold) else $error("partner word moved");
  a_done_idle: assert property (p_done_idle) else $error("done without idles");
  a_done_in: assert property (p_done_in) else $error("done without partner idles");
  a_sync_loss: assert property (p_sync_loss) else $error("link kept after sync loss");
  c_page: cover property ($rose(PAGE_RECEIVED_FLAG));
  c_done: cover property ($rose(NEGOTIATION_DONE_FLAG));
  c_sync: cover property ($fell(SYNC_OK));
endmodule
`default_nettype wire

// file: tb/gbe_sgmii_autoneg_control_tb.sv
// bench: register-driven negotiation runs against a partner model
// assumes checker and partner model are compiled before this file
`timescale 1ns/1ps
`default_nettype none
module gbe_sgmii_autoneg_control_tb;
  import an_pkg::*;
  localparam int SG = 40;
  localparam int GB = 60;
  localparam int SH = 10;
  localparam int LIMIT = 20000;
  logic sys_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready, sync_hold;
  logic awready, wready, bvalid, arready, rvalid, irq, page, done;
  logic cfg_valid, idle_in, sync_ok, cfg_send, idle_send;
  logic [7:0] awaddr, araddr, gap;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] cfg_in, cfg_out, partner_word, first_tx, ability;
  int error_cnt, samples_checked, cyc;
  ////////////////////////////////////////
  an_control #(.SGMII_CYC(SG), .GBE_CYC(GB), .SHORT_CYC(SH)) u_dut (
    .SYS_CLK(sys_clk), .SYS_RST(sys_rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .RX_CFG_VALID(cfg_valid), .RX_CFG_WORD(cfg_in), .RX_IDLE(idle_in), .SYNC_OK(sync_ok),
    .TX_CFG_SEND(cfg_send), .TX_CFG_WORD(cfg_out), .TX_IDLE_SEND(idle_send),
    .PARTNER_ABILITY_WORD(partner_word), .PAGE_RECEIVED_FLAG(page),
    .NEGOTIATION_DONE_FLAG(done), .IRQ(irq)
  );
  link_partner_model u_partner (
    .clk(sys_clk), .rst(sys_rst), .tx_cfg_send(cfg_send), .tx_cfg_word(cfg_out),
    .tx_idle_send(idle_send), .gap(gap), .ability(ability), .sync_hold(sync_hold),
    .rx_cfg_valid(cfg_valid), .rx_cfg_word(cfg_in), .rx_idle(idle_in), .sync_ok(sync_ok)
  );
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // watchdog and capture of the first non-zero word sent
  always @(posedge sys_clk) begin
    cyc++;
    if (first_tx == 16'h0000 && cfg_send && cfg_out != 16'h0000) first_tx <= cfg_out;
    if (cyc == LIMIT) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw, ga, gw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw) begin
      @(negedge sys_clk);
      ga = pa && awready;
      gw = pw && wready;
      @(posedge sys_clk);
      if (ga) awvalid <= 1'b0;
      if (gw) wvalid <= 1'b0;
      pa = pa && !ga;
      pw = pw && !gw;
    end
    do @(negedge sys_clk); while (bvalid !== 1'b1);
    chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, bresp});
    @(posedge sys_clk);
    bready <= 1'b0;
  endtask
  // one read, compared with the expected word and response
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge sys_clk); while (arready !== 1'b1);
    @(posedge sys_clk);
    arvalid <= 1'b0;
    do @(negedge sys_clk); while (rvalid !== 1'b1);
    chk($sformatf("rdata %h", a), e, rdata);
    chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rresp});
    @(posedge sys_clk);
    rready <= 1'b0;
  endtask
  task automatic wait_done();
    do @(negedge sys_clk); while (done !== 1'b1);
  endtask
  // restart, time the zero-word phase, negotiate to link up
  task automatic run(input logic [31:0] ctrl, input int len, input logic [15:0] etx);
    int n;
    first_tx = 16'h0000;
    wr(OFS_CTRL, ctrl, RESP_OKAY);
    do @(negedge sys_clk); while (!(cfg_out == 16'h0000 && !idle_send));
    chk("done_in_restart", 32'h0, {31'h0, done});
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (cfg_out == 16'h0000 && !idle_send);
    chk("timer_len_ok", 32'h1, {31'h0, n >= len && n <= len + 3});
    wait_done();
    chk("first_tx", {16'h0, etx}, {16'h0, first_tx});
    chk("partner_word", {16'h0, ability | 16'h4000}, {16'h0, partner_word});
    rdc(OFS_STATUS, 32'h27, RESP_OKAY);
  endtask
  ////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    gap = 8'h03;
    ability = 16'h9801;
    sync_hold = 1'b0;
    first_tx = 16'h0000;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // reset values and an unmapped place
    rdc(OFS_CTRL, {27'h0, CTRL_RESET}, RESP_OKAY);
    rdc(OFS_LOCAL, {16'h0, LOCAL_RESET}, RESP_OKAY);
    rdc(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
    rdc(8'h18, 32'h0, RESP_SLVERR);
    wr(8'h18, 32'hFFFF_FFFF, RESP_SLVERR);
    wait_done();
    // mac side through every timer length, prompt then slow partner
    run(32'h0B, SH, MAC_SIDE_WORD);
    gap <= 8'h14;
    run(32'h03, SG, MAC_SIDE_WORD);
    run(32'h13, GB, LOCAL_RESET);
    wr(OFS_LOCAL, 32'h0000_9A01, RESP_OKAY);
    repeat (5) @(negedge sys_clk);
    chk("mac_keeps_link", 32'h1, {31'h0, done});
    // phy side sends its own word and restarts on a change
    run(32'h0F, SH, 16'h9A01);
    rdc(OFS_CTRL, 32'h0D, RESP_OKAY);
    wr(OFS_LOCAL, 32'h0000_9801, RESP_OKAY);
    repeat (5) @(negedge sys_clk);
    chk("phy_restarts", 32'h0, {31'h0, done});
    wait_done();
    // disabled: idles only, state parked
    wr(OFS_CTRL, 32'h08, RESP_OKAY);
    repeat (3) @(negedge sys_clk);
    chk("disabled_tx", 32'h0001_0000, {15'h0, idle_send, cfg_out});
    rdc(OFS_STATUS, 32'h05, RESP_OKAY);
    run(32'h0B, SH, MAC_SIDE_WORD);
    // sync loss: masked, unmasked, then cleared interrupt
    wr(OFS_IRQ_STAT, 32'h0F, RESP_OKAY);
    rdc(OFS_IRQ_STAT, 32'h0, RESP_OKAY);
    sync_hold <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sync_hold <= 1'b0;
    @(negedge sys_clk);
    chk("link_after_sync_loss", 32'h0, {30'h0, irq, done});
    wr(OFS_IRQ_MASK, 32'h04, RESP_OKAY);
    @(negedge sys_clk);
    chk("irq_unmasked", 32'h1, {31'h0, irq});
    wr(OFS_IRQ_STAT, 32'h04, RESP_OKAY);
    @(negedge sys_clk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    wait_done();
    // page entry, link up and restart stay latched, link down cleared
    rdc(OFS_IRQ_STAT, 32'h0B, RESP_OKAY);
    // byte lanes: only the lowest lane lands
    wstrb <= 4'h1;
    wr(OFS_LOCAL, 32'hFFFF_FF55, RESP_OKAY);
    wstrb <= 4'hF;
    rdc(OFS_LOCAL, 32'h0000_9855, RESP_OKAY);
    end_sim();
  end
endmodule
bind an_control an_control_checker #(.GBE_CYC(GBE_CYC), .SHORT_CYC(SHORT_CYC)) u_chk (
  .SYS_CLK, .SYS_RST, .RX_CFG_VALID, .RX_CFG_WORD, .RX_IDLE, .SYNC_OK, .TX_CFG_SEND,
  .TX_CFG_WORD, .TX_IDLE_SEND, .PARTNER_ABILITY_WORD, .PAGE_RECEIVED_FLAG,
  .NEGOTIATION_DONE_FLAG
);
`default_nettype wire

// file: tb/link_partner_model.sv
// link partner model: paced config words, ack, idles, sync
// assumes the same clock as the block under test
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // from the block
  input wire logic tx_cfg_send,
  input wire logic [15:0] tx_cfg_word,
  input wire logic tx_idle_send,
  // behaviour set by the bench
  input wire logic [7:0] gap,
  input wire logic [15:0] ability,
  input wire logic sync_hold,
  // towards the block
  output logic rx_cfg_valid,
  output logic [15:0] rx_cfg_word,
  output logic rx_idle,
  output logic sync_ok
);
  logic [7:0] cnt;
  logic ack;
  logic [15:0] word;
  ////////////////////////////////////////
  // one config word every gap+1 cycles while the block sends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      rx_cfg_valid <= 1'b0;
      word <= 16'h0000;
      ack <= 1'b0;
    end else begin
      cnt <= (cnt >= gap) ? 8'h00 : cnt + 8'h01;
      rx_cfg_valid <= tx_cfg_send && cnt >= gap;
      if (tx_cfg_send && cnt >= gap)
        word <= (tx_cfg_word == 16'h0000) ? 16'h0000 : ability | {1'b0, ack, 14'h0000};
      if (tx_cfg_send && tx_cfg_word == 16'h0000) ack <= 1'b0;
      else if (rx_cfg_valid && word != 16'h0000) ack <= 1'b1;
    end
  end
  // idles answer idles, sync held off on request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_idle <= 1'b0;
      sync_ok <= 1'b1;
    end else begin
      rx_idle <= tx_idle_send;
      sync_ok <= !sync_hold;
    end
  end
  // a released word line shows the inverse of the last word
  assign rx_cfg_word = rx_cfg_valid ? word : ~word;
endmodule
`default_nettype wire
